/* File: src/pwm_timer_pkg.sv */
// Package: register map, field layout, modes and prescaler constants of the PWM timer
package pwm_timer_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMP_A = 8'h04;
    localparam logic [7:0] OFS_CMP_B = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // ==========================================================
    // Field positions
    localparam int MODE_LSB = 0;
    localparam int ACT_B_LSB = 4;
    localparam int ACT_A_LSB = 6;
    localparam int CLKSEL_LSB = 8;
    localparam int OVF_BIT = 0;
    localparam int MATCH_A_BIT = 1;
    localparam int MATCH_B_BIT = 2;

    // ==========================================================
    // Reset values
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] CMP_RESET = 8'h00;
    localparam logic [2:0] STATUS_RESET = 3'h0;

    // ==========================================================
    // Modes, actions, limits
    localparam logic [2:0] MODE_PC_FF = 3'h1;
    localparam logic [2:0] MODE_FAST_FF = 3'h3;
    localparam logic [2:0] MODE_PC_CMP = 3'h5;
    localparam logic [2:0] MODE_FAST_CMP = 3'h7;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_NONINV = 2'h2;
    localparam logic [1:0] ACT_INV = 2'h3;
    localparam logic [7:0] VAL_BOTTOM = 8'h00;
    localparam logic [7:0] VAL_MAX = 8'hFF;

    // ==========================================================
    // Prescaler: select codes and low-bit masks (divide by 1, 8, 64, 256, 1024)
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [9:0] MASK_DIV8 = 10'h007;
    localparam logic [9:0] MASK_DIV64 = 10'h03F;
    localparam logic [9:0] MASK_DIV256 = 10'h0FF;
    localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

    typedef struct packed {
        logic [20:0] unused;
        logic [2:0] clk_sel;
        logic [1:0] output_action_a;
        logic [1:0] output_action_b;
        logic wave_mode_upper_bit;
        logic [2:0] wave_mode_field;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '0;

endpackage

/* File: src/pwm_timer.sv */
// Top: 8-bit timer with fast and phase-correct PWM on two channels behind APB
// Contract
// - Modes 3 and 7 are fast PWM; top is 0xFF or compare A.
// - Fast PWM counts up to top, then clears to bottom on next tick.
// - Fast action 2: clear on match, set on wrap to bottom.
// - Fast action 3: set on match, clear on wrap to bottom.
// - Fast PWM sets overflow flag when counter reaches top.
// - Fast action 1 toggles channel A on match only with mode upper bit.
// - Top 0xFF gives a fast period of 256 ticks.
// - Prescaler divides the clock by 1, 8, 64, 256, 1024.
// - Fast compare bottom gives one-tick spike; max gives constant level.
// - Fast toggle gives 50% square wave, half clock at compare zero.
// - Compare values double buffered in PWM, loaded at update point.
// - Modes 1 and 5 are phase-correct; top is 0xFF or compare A.
// - Phase-correct counts up to top, down to bottom; top held one tick.
// - Phase-correct action 2 clears on up match, sets on down; 3 opposite.
// - Phase-correct sets overflow flag when counter reaches bottom.
// - Phase-correct action 1 toggles channel A only with mode upper bit.
// - Top 0xFF gives a phase-correct period of 510 ticks.
// - Phase-correct compare bottom holds low, max holds high (non-inverted).
// - Output takes up-match level without match when compare leaves max.
// - Fully synchronous; tick only enables counting, flag setting, output changes and PWM compare loads.
`timescale 1ns/1ns
`default_nettype none
module pwm_timer (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic WAVE_OUT_A,
    output logic WAVE_OUT_B
);
    import pwm_timer_pkg::*;

    // ==========================================================
    // Register state
    ctrl_t ctrl_reg;
    logic [7:0] count_value_reg;
    logic [7:0] cmp_buf_reg [2];
    logic [7:0] cmp_act_reg [2];
    logic [2:0] status_reg;
    logic [9:0] presc_reg;
    logic dir_up_reg;
    logic block_reg;
    logic [1:0] seen_up_reg;
    logic [1:0] wave_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    // ==========================================================
    // Decode
    logic setup_phase;
    logic access_done;
    logic wr_en;
    logic addr_ok;
    logic fast_mode;
    logic pc_mode;
    logic pwm_mode;
    logic [7:0] top_val;
    logic timer_tick;
    logic at_top;
    logic at_bottom;
    logic up_phase;
    logic [1:0] match;
    logic [1:0] act [2];

    assign setup_phase = PSEL && !PENABLE;
    assign access_done = PSEL && PENABLE && pready_reg;
    assign wr_en = access_done && PWRITE && !pslverr_reg;
    assign addr_ok = (PADDR == OFS_CTRL) || (PADDR == OFS_CMP_A) || (PADDR == OFS_CMP_B)
        || (PADDR == OFS_COUNT) || (PADDR == OFS_STATUS);

    // Mode decode and top selection
    assign fast_mode = (ctrl_reg.wave_mode_field == MODE_FAST_FF)
        || (ctrl_reg.wave_mode_field == MODE_FAST_CMP);
    assign pc_mode = (ctrl_reg.wave_mode_field == MODE_PC_FF)
        || (ctrl_reg.wave_mode_field == MODE_PC_CMP);
    assign pwm_mode = fast_mode || pc_mode;
    assign top_val = ctrl_reg.wave_mode_field[2] ? cmp_act_reg[0] : VAL_MAX;

    assign at_top = timer_tick && (count_value_reg == top_val);
    assign at_bottom = timer_tick && (count_value_reg == VAL_BOTTOM);
    // Bottom counts as the start of the up slope
    assign up_phase = dir_up_reg || (count_value_reg == VAL_BOTTOM);
    assign act[0] = ctrl_reg.output_action_a;
    assign act[1] = ctrl_reg.output_action_b;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_match
            assign match[gi] = timer_tick && !block_reg
                && (count_value_reg == cmp_act_reg[gi]);
        end
    endgenerate

    // ==========================================================
    // Prescaler: free-running divider, tick is a one-cycle enable
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_reg + 10'h001;
        end
    end

    always_comb begin
        case (ctrl_reg.clk_sel)
            CS_DIV1: timer_tick = 1'b1;
            CS_DIV8: timer_tick = (presc_reg & MASK_DIV8) == MASK_DIV8;
            CS_DIV64: timer_tick = (presc_reg & MASK_DIV64) == MASK_DIV64;
            CS_DIV256: timer_tick = (presc_reg & MASK_DIV256) == MASK_DIV256;
            CS_DIV1024: timer_tick = presc_reg == MASK_DIV1024;
            default: timer_tick = 1'b0;
        endcase
    end

    // ==========================================================
    // APB slave: zero wait states, answer registered in the setup cycle
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= setup_phase;
            pslverr_reg <= setup_phase && !addr_ok;
            if (setup_phase && !PWRITE) begin
                case (PADDR)
                    OFS_CTRL: prdata_reg <= ctrl_reg;
                    OFS_CMP_A: prdata_reg <= {24'h000000, cmp_buf_reg[0]};
                    OFS_CMP_B: prdata_reg <= {24'h000000, cmp_buf_reg[1]};
                    OFS_COUNT: prdata_reg <= {24'h000000, count_value_reg};
                    OFS_STATUS: prdata_reg <= {29'h0, status_reg};
                    default: prdata_reg <= '0;
                endcase
            end else if (setup_phase) begin
                prdata_reg <= '0;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_en && PADDR == OFS_CTRL) begin
            ctrl_reg <= {21'h0, PWDATA[10:0]};
        end
    end

    // ==========================================================
    // Compare buffers: loaded at the update point while in PWM
    generate
        for (gi = 0; gi < 2; gi++) begin : g_cmp
            logic cmp_wr;
            assign cmp_wr = wr_en && (PADDR == (gi == 0 ? OFS_CMP_A : OFS_CMP_B));
            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    cmp_buf_reg[gi] <= CMP_RESET;
                    cmp_act_reg[gi] <= CMP_RESET;
                end else begin
                    if (cmp_wr) begin
                        cmp_buf_reg[gi] <= PWDATA[7:0];
                    end
                    if (!pwm_mode && cmp_wr) begin
                        cmp_act_reg[gi] <= PWDATA[7:0];
                    end else if (!pwm_mode || (at_top && dir_up_reg)) begin
                        cmp_act_reg[gi] <= cmp_buf_reg[gi];
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Counter and direction
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            count_value_reg <= COUNT_RESET;
            dir_up_reg <= 1'b1;
            block_reg <= 1'b0;
        end else if (wr_en && PADDR == OFS_COUNT) begin
            count_value_reg <= PWDATA[7:0];
            block_reg <= 1'b1;
        end else if (timer_tick) begin
            block_reg <= 1'b0;
            if (fast_mode) begin
                dir_up_reg <= 1'b1;
                count_value_reg <= at_top ? VAL_BOTTOM : count_value_reg + 8'h01;
            end else if (pc_mode) begin
                if (dir_up_reg && at_top) begin
                    dir_up_reg <= 1'b0;
                    count_value_reg <= (top_val == VAL_BOTTOM) ? VAL_BOTTOM
                        : count_value_reg - 8'h01;
                end else if (!dir_up_reg && at_bottom) begin
                    dir_up_reg <= 1'b1;
                    count_value_reg <= (top_val == VAL_BOTTOM) ? VAL_BOTTOM
                        : count_value_reg + 8'h01;
                end else if (dir_up_reg) begin
                    count_value_reg <= count_value_reg + 8'h01;
                end else begin
                    count_value_reg <= count_value_reg - 8'h01;
                end
            end else begin
                dir_up_reg <= 1'b1;
                count_value_reg <= count_value_reg + 8'h01;
            end
        end
    end

    // ==========================================================
    // Status flags: write one to clear, hardware set wins
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    assign flag_set[OVF_BIT] = (fast_mode && at_top)
        || (pc_mode && at_bottom && !dir_up_reg)
        || (!pwm_mode && timer_tick && count_value_reg == VAL_MAX);
    assign flag_set[MATCH_A_BIT] = match[0];
    assign flag_set[MATCH_B_BIT] = match[1];
    assign flag_clr = (wr_en && PADDR == OFS_STATUS) ? PWDATA[2:0] : 3'h0;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            status_reg <= STATUS_RESET;
        end else begin
            status_reg <= (status_reg & ~flag_clr) | flag_set;
        end
    end

    // ==========================================================
    // Waveform outputs, held across counter writes and mode changes
    generate
        for (gi = 0; gi < 2; gi++) begin : g_wave
            logic toggle_ok;
            logic top_cmp_new;
            logic pc_match;
            logic up_level;
            assign toggle_ok = (gi == 0) && ctrl_reg.wave_mode_upper_bit;
            assign top_cmp_new = cmp_buf_reg[gi] == top_val;
            assign pc_match = match[gi] && (cmp_act_reg[gi] != top_val);
            assign up_level = act[gi] == ACT_INV;

            always_ff @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    wave_reg[gi] <= 1'b0;
                    seen_up_reg[gi] <= 1'b0;
                end else if (fast_mode) begin
                    if (act[gi] == ACT_TOGGLE) begin
                        if (toggle_ok && match[gi]) begin
                            wave_reg[gi] <= !wave_reg[gi];
                        end
                    end else if (act[gi][1] && at_top) begin
                        wave_reg[gi] <= act[gi] == ACT_NONINV;
                    end else if (act[gi][1] && match[gi]) begin
                        wave_reg[gi] <= act[gi] == ACT_INV;
                    end
                end else if (pc_mode) begin
                    if (at_top && dir_up_reg) begin
                        seen_up_reg[gi] <= 1'b0;
                    end else if (pc_match && up_phase) begin
                        seen_up_reg[gi] <= 1'b1;
                    end
                    if (act[gi] == ACT_TOGGLE) begin
                        if (toggle_ok && match[gi]) begin
                            wave_reg[gi] <= !wave_reg[gi];
                        end
                    end else if (act[gi][1] && at_top && dir_up_reg) begin
                        if (top_cmp_new) begin
                            wave_reg[gi] <= !up_level;
                        end else if (!seen_up_reg[gi] && !(pc_match && up_phase)) begin
                            wave_reg[gi] <= up_level;
                        end
                    end else if (act[gi][1] && pc_match) begin
                        wave_reg[gi] <= up_phase ? up_level : !up_level;
                    end
                end
            end
        end
    endgenerate

    // ==========================================================
    // Outputs straight from flip-flops
    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign WAVE_OUT_A = wave_reg[0];
    assign WAVE_OUT_B = wave_reg[1];

    // ==========================================================
    // Assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    sequence s_fast_wrap;
        fast_mode && at_top && !(wr_en && PADDR == OFS_COUNT);
    endsequence

    sequence s_pc_turn;
        pc_mode && at_top && dir_up_reg && top_val != VAL_BOTTOM
            && !(wr_en && PADDR == OFS_COUNT);
    endsequence

    a_fast_wrap_bottom: assert property (
        s_fast_wrap |=> count_value_reg == VAL_BOTTOM)
        else $error("fast pwm did not wrap to bottom");

    a_fast_set_bottom: assert property (
        s_fast_wrap ##0 (act[0] == ACT_NONINV) ##0 !(wr_en && PADDR == OFS_CTRL)
            |=> WAVE_OUT_A)
        else $error("non-inverted output not set at wrap");

    a_fast_inv_match: assert property (
        fast_mode && act[0] == ACT_INV && match[0] && !at_top
            && !(wr_en && PADDR == OFS_CTRL) |=> WAVE_OUT_A)
        else $error("inverted output not set on match");

    a_fast_ovf_top: assert property (
        s_fast_wrap |=> status_reg[OVF_BIT])
        else $error("overflow flag not set at top");

    a_toggle_gate_b: assert property (
        fast_mode && act[1] == ACT_TOGGLE && !(wr_en && PADDR == OFS_CTRL)
            |=> $stable(WAVE_OUT_B))
        else $error("channel b toggled");

    a_pc_turn_down: assert property (
        s_pc_turn |=> !dir_up_reg && count_value_reg == $past(count_value_reg) - 8'h01)
        else $error("phase correct did not turn at top");

    a_pc_ovf_bottom: assert property (
        pc_mode && at_bottom && !dir_up_reg |=> status_reg[OVF_BIT])
        else $error("overflow flag not set at bottom");

    a_pc_noninv_up: assert property (
        pc_mode && act[0] == ACT_NONINV && match[0] && dir_up_reg && !at_top
            && cmp_act_reg[0] != top_val && !(wr_en && PADDR == OFS_CTRL)
            |=> !WAVE_OUT_A)
        else $error("non-inverted output not cleared on up match");

    a_pc_noninv_down: assert property (
        pc_mode && act[0] == ACT_NONINV && match[0] && !up_phase
            && cmp_act_reg[0] != top_val && !(wr_en && PADDR == OFS_CTRL)
            |=> WAVE_OUT_A)
        else $error("non-inverted output not set on down match");

    a_fast_clear_match: assert property (
        fast_mode && act[0] == ACT_NONINV && match[0] && !at_top
            && !(wr_en && PADDR == OFS_CTRL) |=> !WAVE_OUT_A)
        else $error("non-inverted output not cleared on match");

    a_count_idle: assert property (
        !timer_tick && !(wr_en && PADDR == OFS_COUNT) |=> $stable(count_value_reg))
        else $error("counter moved without a tick");

    a_tick_div8: assert property (
        ctrl_reg.clk_sel == CS_DIV8 && timer_tick && !(wr_en && PADDR == OFS_CTRL)
            |=> (!timer_tick || ctrl_reg.clk_sel != CS_DIV8) [*7])
        else $error("divide by 8 tick spacing wrong");

    a_cmp_buffered: assert property (
        pwm_mode && !(at_top && dir_up_reg) && !(wr_en && PADDR == OFS_CTRL)
            |=> $stable(cmp_act_reg[0]))
        else $error("compare loaded outside update point");

    a_apb_answer: assert property (
        setup_phase |=> PREADY)
        else $error("apb did not answer in one cycle");

endmodule
`default_nettype wire

/* File: bench/wave_load.sv */
// Load model: measures period and high time of one waveform pin
`timescale 1ns/1ns
`default_nettype none
module wave_load (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic wave,
    output logic [31:0] meas,
    output logic done
);
    logic prev_reg;
    logic seen_reg;
    logic [15:0] cnt_reg;
    logic [15:0] high_reg;

    // ==========================================================
    // Period {cycles, high cycles} reported at each rising edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_reg <= 1'b0;
            seen_reg <= 1'b0;
            cnt_reg <= 16'h0000;
            high_reg <= 16'h0000;
            meas <= 32'h0000_0000;
            done <= 1'b0;
        end else begin
            prev_reg <= wave;
            done <= 1'b0;
            if (wave && !prev_reg) begin
                meas <= {cnt_reg, high_reg};
                done <= seen_reg;
                seen_reg <= 1'b1;
                cnt_reg <= 16'h0001;
                high_reg <= 16'h0001;
            end else begin
                cnt_reg <= cnt_reg + 16'h0001;
                high_reg <= high_reg + {15'h0000, wave};
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/timer_pwm_waveform_modes_bench.sv */
// Testbench: APB-driven PWM timer with measured waveforms
`timescale 1ns/1ns
`default_nettype none
module timer_pwm_waveform_modes_bench;
    import pwm_timer_pkg::*;
    logic clk, rst_b, psel, penable, pwrite, pready, pslverr, wave_a, wave_b, done_a, done_b;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, meas_a, meas_b;
    logic [33:0] rd_e;
    logic [33:0] rq[$];
    logic [31:0] qa[$];
    logic [31:0] qb[$];
    int fails = 0;
    int checks = 0;
    int ra, rb, k;

    pwm_timer i_dut (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .WAVE_OUT_A(wave_a), .WAVE_OUT_B(wave_b));
    wave_load i_load_a (.clk(clk), .rst_b(rst_b), .wave(wave_a), .meas(meas_a), .done(done_a));
    wave_load i_load_b (.clk(clk), .rst_b(rst_b), .wave(wave_b), .meas(meas_b), .done(done_b));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ==========================================================
    // Checking and closing
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    always @(negedge clk) begin
        if (psel && penable && pready === 1'b1 && rq.size() > 0) begin
            rd_e = rq.pop_front();
            chk({31'h0, pslverr}, {31'h0, rd_e[32]});
            if (!rd_e[33]) chk(prdata, rd_e[31:0]);
        end
        if (done_a === 1'b1 && qa.size() > 0) chk(meas_a, qa.pop_front());
        if (done_b === 1'b1 && qb.size() > 0) chk(meas_b, qb.pop_front());
    end

    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        tally_and_finish();
    end

    // ==========================================================
    // Drivers
    function automatic logic [31:0] ctrl(input logic [2:0] m, input logic [1:0] aa,
        input logic [1:0] ab, input logic [2:0] cs);
        ctrl_t c;
        c = CTRL_RESET;
        c.wave_mode_field = m;
        c.wave_mode_upper_bit = m[2];
        c.output_action_a = aa;
        c.output_action_b = ab;
        c.clk_sel = cs;
        return c;
    endfunction

    // Read: d is the expected data
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
        int n;
        n = 0;
        rq.push_back({w, e, d});
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(negedge clk);
        while (pready !== 1'b1 && n < 16) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        if (n >= 16) begin
            fails++;
            tally_and_finish();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Skip settling periods, then expect one full period on each channel given a nonzero period
    task automatic measure(input int pa, input int ha, input int pb, input int hb);
        int na, nb, n;
        na = 0;
        nb = 0;
        n = 0;
        while (((pa > 0 && na < 3) || (pb > 0 && nb < 3)) && n < 20000) begin
            @(negedge clk);
            na += int'(done_a === 1'b1);
            nb += int'(done_b === 1'b1);
            n++;
        end
        if (pa > 0) qa.push_back({pa[15:0], ha[15:0]});
        if (pb > 0) qb.push_back({pb[15:0], hb[15:0]});
        while ((qa.size() > 0 || qb.size() > 0) && n < 40000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 40000) begin
            fails++;
            tally_and_finish();
        end
    endtask

    task automatic hold(input logic l);
        int bad;
        bad = 0;
        repeat (600) @(negedge clk);
        repeat (520) begin
            @(negedge clk);
            bad += int'(wave_a !== l);
        end
        chk(bad, 0);
    endtask

    // ==========================================================
    // Scenarios
    initial begin
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        void'($urandom(22973));
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 5; i++) apb(1'b0, 8'(4 * i), 32'h0, 1'b0);
        apb(1'b0, 8'h14, 32'h0, 1'b1);
        apb(1'b1, 8'h14, 32'hFF, 1'b1);
        ra = $urandom_range(254, 1);
        rb = $urandom_range(254, 1);
        apb(1'b1, OFS_CMP_A, ra, 1'b0);
        apb(1'b1, OFS_CMP_B, rb, 1'b0);
        apb(1'b0, OFS_CMP_A, ra, 1'b0);
        apb(1'b1, OFS_CTRL, ctrl(MODE_FAST_FF, ACT_NONINV, ACT_INV, CS_DIV1), 1'b0);
        measure(256, ra + 1, 256, 255 - rb);
        apb(1'b0, OFS_STATUS, 32'h7, 1'b0);
        apb(1'b1, OFS_CTRL, ctrl(MODE_FAST_FF, ACT_NONINV, ACT_INV, CS_DIV8), 1'b0);
        measure(2048, (ra + 1) * 8, 2048, (255 - rb) * 8);
        apb(1'b1, OFS_CTRL, ctrl(MODE_FAST_FF, ACT_NONINV, ACT_INV, CS_DIV1), 1'b0);
        apb(1'b1, OFS_CMP_A, VAL_BOTTOM, 1'b0);
        measure(256, 1, 0, 0);
        apb(1'b1, OFS_CMP_A, VAL_MAX, 1'b0);
        hold(1'b1);
        apb(1'b1, OFS_CTRL, ctrl(MODE_FAST_FF, ACT_TOGGLE, ACT_TOGGLE, CS_DIV1), 1'b0);
        hold(1'b1);
        for (int i = 0; i < 2; i++) begin
            k = (i == 0) ? 0 : $urandom_range(20, 1);
            apb(1'b1, OFS_CMP_A, k, 1'b0);
            apb(1'b1, OFS_CTRL, ctrl(MODE_FAST_CMP, ACT_TOGGLE, ACT_NONINV, CS_DIV1), 1'b0);
            measure(2 * (k + 1), k + 1, 0, 0);
        end
        ra = $urandom_range(254, 1);
        rb = $urandom_range(254, 1);
        apb(1'b1, OFS_CMP_A, ra, 1'b0);
        apb(1'b1, OFS_CMP_B, rb, 1'b0);
        apb(1'b1, OFS_CTRL, ctrl(MODE_PC_FF, ACT_NONINV, ACT_INV, CS_DIV1), 1'b0);
        measure(510, 2 * ra, 510, 510 - 2 * rb);
        apb(1'b1, OFS_CMP_A, VAL_BOTTOM, 1'b0);
        hold(1'b0);
        apb(1'b1, OFS_CMP_A, VAL_MAX, 1'b0);
        hold(1'b1);
        k = $urandom_range(200, 20);
        rb = $urandom_range(k - 1, 1);
        apb(1'b1, OFS_CMP_A, k, 1'b0);
        apb(1'b1, OFS_CMP_B, rb, 1'b0);
        apb(1'b1, OFS_CTRL, ctrl(MODE_PC_CMP, ACT_NONINV, ACT_NONINV, CS_DIV1), 1'b0);
        measure(0, 0, 2 * k, 2 * rb);
        tally_and_finish();
    end
endmodule
`default_nettype wire
